// file: src/buck_regulator_control_regs.sv
// Serial-bus register bank controlling three step-down regulator channels.
`include "buck_regs_cfg.svh"
module buck_regulator_control_regs #(
  parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEF
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Two-wire serial bus, sampled on the system clock.
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Switching-cycle tick and read-only status.
  input wire logic i_sw_tick,
  input wire logic [7:0] i_status,
  // Regulator controls.
  output logic o_ch1_disable,
  output logic o_ch2_disable,
  output logic o_ch3_disable,
  output logic o_ch1_light_load_sel,
  output logic o_ch2_light_load_sel,
  output logic o_ch3_light_load_sel,
  output logic o_vid_go,
  output logic [6:0] o_voltage_code,
  output logic [6:0] o_target_code,
  output logic [15:0] o_target_mv,
  output logic o_transition_busy
);
  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [7:0] buck2_voltage_select;
  logic [7:0] buck1_command;
  logic [7:0] buck2_command;
  logic [7:0] buck3_command;
  logic [7:0] reg_pointer;

  // ****************************************************************
  // How the block is meant to be used.
  // ****************************************************************
  // The bus lines arrive as plain levels on the system clock.
  // The master must hold every bus level for at least two clocks.
  // A shorter level may be missed or read as a false edge.
  // Start and stop are recognised from two samples with the bus clock high.
  // A data line move inside that window is never taken as a data bit.
  // The master changes data only while the bus clock is low.
  //
  // A write runs as start, address with write bit, register byte, data byte.
  // Each byte is acknowledged by pulling the data line low for one slot.
  // The register takes its new value as the last data bit ends.
  // It does so before the acknowledge slot, so the master sees it applied.
  // Further data bytes in the same transfer go to the next addresses.
  // A write to an unmapped address is acknowledged and then dropped.
  // A foreign slave address is ignored until the next start.
  //
  // Reads are an extra and return the byte at the current pointer.
  // The status byte is passed through from outside as it stands.
  // It is sampled as each bit is shifted, so it may change mid byte.
  // A master that needs a coherent status byte should read it twice.
  //
  // The command registers hold an enable bit that is active low.
  // After reset every channel therefore stands enabled.
  // That matches a cleared register and needs no special reset value.
  // The light-load bit picks continuous switching at zero.
  // At one the channel is forced into pulse skipping.
  // The spare bits of every register are stored and read back.
  // They drive nothing, so software may use them as scratch.
  //
  // The voltage code drives the second channel only with the go bit set.
  // With go clear the paced target stays where it is.
  // The real output then follows the external feedback network.
  // When go is set, the target walks one code at a time to the code.
  // Each code step is worth ten millivolts on the output.
  // The pace is one step per 2^N switching ticks, N from the slew field.
  // A new code written mid walk simply redirects the walk.
  // The pace counter restarts whenever the walk is idle.
  // So the first step of a walk always waits a whole period.
  // This trades a little latency for a clean, repeatable start.
  //
  // The millivolt output is an arithmetic view of the target.
  // It is for monitoring and for the bench, not for the regulator loop.
  // It spans 680 mV at code zero to 1950 mV at the top code.
  //
  // The data line output enable is registered.
  // It therefore moves one clock after the bus clock falls.
  // This keeps the acknowledge clear of the bus clock high phase.
  // The data output value itself is always low, as on an open drain.
  // The pull-up outside provides the high level when released.
  //
  // Reset is synchronous and clears every register and the target.
  // The edge detectors reset to the idle high level of both lines.
  // This prevents a false start straight after reset.
  // The bus is usable from the first clock after reset is released.
  // A transfer cut by reset is simply lost; the master must restart it.

  // ****************************************************************
  // Serial line tracking.
  // ****************************************************************
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  buck_regs_pkg::ser_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic ack_phase;
  logic read_mode;
  logic [7:0] rd_byte;
  logic write_now;
  logic [7:0] next_shift;

  assign scl_rise = i_scl && !scl_d;
  assign scl_fall = !i_scl && scl_d;
  // Data changing while the clock is high marks start or stop.
  assign start_seen = i_scl && scl_d && sda_d && !i_sda;
  assign stop_seen = i_scl && scl_d && !sda_d && i_sda;
  assign next_shift = {shift[6:0], i_sda};

  // Previous line levels for edge detection.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= i_scl;
      sda_d <= i_sda;
    end
  end

  // Byte framing: eight data bits then an acknowledge slot.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= buck_regs_pkg::SER_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      read_mode <= 1'b0;
    end else if (start_seen) begin
      state <= buck_regs_pkg::SER_DEVADDR;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      read_mode <= 1'b0;
    end else if (stop_seen) begin
      state <= buck_regs_pkg::SER_IDLE;
      ack_phase <= 1'b0;
    end else if (state != buck_regs_pkg::SER_IDLE) begin
      if (scl_rise && !ack_phase && !read_mode) begin
        shift <= next_shift;
        bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_rise && read_mode && !ack_phase) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (scl_fall && bit_cnt == 4'h8 && !ack_phase) begin
        ack_phase <= 1'b1;
        bit_cnt <= 4'h0;
        // A foreign address ends our part in this transfer without acknowledge.
        if (state == buck_regs_pkg::SER_DEVADDR && shift[7:1] != SLAVE_ADDR) begin
          state <= buck_regs_pkg::SER_IDLE;
          ack_phase <= 1'b0;
        end else if (state == buck_regs_pkg::SER_DEVADDR) begin
          read_mode <= shift[0];
        end
      end else if (scl_fall && ack_phase) begin
        ack_phase <= 1'b0;
        unique case (state)
          buck_regs_pkg::SER_IDLE: state <= buck_regs_pkg::SER_IDLE;
          buck_regs_pkg::SER_DEVADDR: begin
            state <= read_mode ? buck_regs_pkg::SER_DATA : buck_regs_pkg::SER_REGADDR;
          end
          buck_regs_pkg::SER_REGADDR: state <= buck_regs_pkg::SER_DATA;
          buck_regs_pkg::SER_DATA: state <= buck_regs_pkg::SER_DATA;
        endcase
      end
    end
  end

  // Update is applied as the data byte completes, ahead of its acknowledge.
  assign write_now = scl_fall && bit_cnt == 4'h8 && !ack_phase && !read_mode
    && state == buck_regs_pkg::SER_DATA;

  // Register pointer loads from the register address byte and steps after each data byte.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reg_pointer <= 8'h00;
    end else if (scl_fall && bit_cnt == 4'h8 && !ack_phase
        && state == buck_regs_pkg::SER_REGADDR) begin
      reg_pointer <= shift;
    end else if (scl_fall && ack_phase && state == buck_regs_pkg::SER_DATA) begin
      reg_pointer <= reg_pointer + 8'h01;
    end
  end

  // ****************************************************************
  // Register writes.
  // ****************************************************************
  // Every bit is stored, spares too, but only the named fields drive anything.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      buck2_voltage_select <= `REG_RESET;
      buck1_command <= `REG_RESET;
      buck2_command <= `REG_RESET;
      buck3_command <= `REG_RESET;
    end else if (write_now) begin
      unique case (reg_pointer)
        `ADDR_VSEL: buck2_voltage_select <= shift;
        `ADDR_CMD1: buck1_command <= shift;
        `ADDR_CMD2: buck2_command <= shift;
        `ADDR_CMD3: buck3_command <= shift;
        default: ;
      endcase
    end
  end

  // Read data for the byte in flight.
  always_comb begin
    unique case (reg_pointer)
      `ADDR_VSEL: rd_byte = buck2_voltage_select;
      `ADDR_CMD1: rd_byte = buck1_command;
      `ADDR_CMD2: rd_byte = buck2_command;
      `ADDR_CMD3: rd_byte = buck3_command;
      `ADDR_STATUS: rd_byte = i_status;
      default: rd_byte = 8'h00;
    endcase
  end

  // Data line drive: pull low for acknowledge, or shift out read bits MSB first.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (start_seen || stop_seen) begin
      o_sda_oe <= 1'b0;
    end else if (scl_fall) begin
      o_sda_out <= 1'b0;
      if (bit_cnt == 4'h8 && !ack_phase && !read_mode) begin
        o_sda_oe <= !(state == buck_regs_pkg::SER_DEVADDR && shift[7:1] != SLAVE_ADDR)
          && state != buck_regs_pkg::SER_IDLE;
      end else if (read_mode && state == buck_regs_pkg::SER_DATA && bit_cnt < 4'h8
          && !(ack_phase && bit_cnt == 4'h0 && 1'b0)) begin
        o_sda_oe <= !rd_byte[3'(4'h7 - bit_cnt)];
      end else if (ack_phase && read_mode && state == buck_regs_pkg::SER_DEVADDR) begin
        o_sda_oe <= !rd_byte[7];
      end else begin
        o_sda_oe <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Regulator controls.
  // ****************************************************************
  assign o_ch1_disable = buck1_command[`CMD_DIS_BIT];
  assign o_ch2_disable = buck2_command[`CMD_DIS_BIT];
  assign o_ch3_disable = buck3_command[`CMD_DIS_BIT];
  assign o_ch1_light_load_sel = buck1_command[`CMD_MODE_BIT];
  assign o_ch2_light_load_sel = buck2_command[`CMD_MODE_BIT];
  assign o_ch3_light_load_sel = buck3_command[`CMD_MODE_BIT];
  assign o_vid_go = buck2_voltage_select[`VSEL_GO_BIT];
  assign o_voltage_code = buck2_voltage_select[`VSEL_CODE_MSB:0];

  // Code-driven target pacing.
  slew_pacer #(
    .CODE_W(7)
  ) u_pacer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_go(o_vid_go),
    .i_code(o_voltage_code),
    .i_slew(buck2_command[`CMD_SLEW_MSB:`CMD_SLEW_LSB]),
    .i_sw_tick(i_sw_tick),
    .o_target(o_target_code),
    .o_moving(o_transition_busy)
  );

  // Target voltage in millivolts, linear from 680 mV at code zero to 1950 mV.
  assign o_target_mv = `MV_BASE + 16'(o_target_code) * `MV_STEP;
endmodule

// file: src/buck_regs_cfg.svh
// Register map, field positions and reset values of the regulator control registers.
`ifndef BUCK_REGS_CFG_SVH
`define BUCK_REGS_CFG_SVH
`define ADDR_VSEL 8'h01
`define ADDR_CMD1 8'h03
`define ADDR_CMD2 8'h04
`define ADDR_CMD3 8'h05
`define ADDR_STATUS 8'h06
`define REG_RESET 8'h00
`define VSEL_GO_BIT 7
`define VSEL_CODE_MSB 6
`define CMD_MODE_BIT 1
`define CMD_DIS_BIT 0
`define CMD_SLEW_MSB 6
`define CMD_SLEW_LSB 4
`define SLAVE_ADDR_DEF 7'h2A
`define CODE_MAX 7'h7F
`define CODE_MIN 7'h00
`define MV_BASE 16'd680
`define MV_STEP 16'd10
`endif

// file: src/buck_regs_pkg.sv
// Types shared by the regulator control register block.
package buck_regs_pkg;
  typedef enum logic [1:0] {SER_IDLE, SER_DEVADDR, SER_REGADDR, SER_DATA} ser_state_t;
  typedef enum logic {LOAD_CONTINUOUS, LOAD_PULSE_SKIP} light_load_t;
endpackage

// file: src/slew_pacer.sv
// Paces the code-driven target of the second channel one step per 2^N switching cycles.
`include "buck_regs_cfg.svh"
module slew_pacer #(
  parameter int CODE_W = 7
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Control.
  input wire logic i_go,
  input wire logic [CODE_W-1:0] i_code,
  input wire logic [2:0] i_slew,
  input wire logic i_sw_tick,
  // Result.
  output logic [CODE_W-1:0] o_target,
  output logic o_moving
);
  logic [6:0] cycle_cnt;
  logic [6:0] period_mask;
  logic step_now;

  initial begin
    if (CODE_W != 7) $error("slew_pacer serves only a 7-bit code");
  end

  // Mask of 2^N-1 sets the number of switching cycles per step.
  assign period_mask = 7'(({7'h00, 1'b1} << i_slew) - 8'h01);
  assign step_now = i_sw_tick && ((cycle_cnt & period_mask) == period_mask);
  assign o_moving = i_go && (o_target != i_code);

  // Cycle counter counts switching ticks while the walk moves and clears when idle, so the pace is kept across steps.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cycle_cnt <= 7'h00;
    end else if (!o_moving) begin
      cycle_cnt <= 7'h00;
    end else if (i_sw_tick) begin
      cycle_cnt <= cycle_cnt + 7'h01;
    end
  end

  // Target moves one code, that is one 10 mV step, toward the programmed code.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_target <= `CODE_MIN;
    end else if (o_moving && step_now) begin
      if (o_target < i_code) begin
        o_target <= o_target + 7'h01;
      end else begin
        o_target <= o_target - 7'h01;
      end
    end
  end
endmodule

// file: tb/buck_regs_asserts.sv
// Concurrent checks on the ports of the regulator control register bank.
module buck_regs_asserts (
  // Clock, reset and bus.
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  // Controls and target.
  input wire logic o_ch1_disable, o_ch2_disable, o_ch3_disable,
  input wire logic o_ch1_light_load_sel, o_ch2_light_load_sel, o_ch3_light_load_sel,
  input wire logic o_vid_go,
  input wire logic [6:0] o_voltage_code,
  input wire logic [6:0] o_target_code,
  input wire logic [15:0] o_target_mv,
  input wire logic o_transition_busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Two samples with the bus clock high; a data move there would read as start or stop.
  sequence s_scl_high2;
    i_scl ##1 i_scl;
  endsequence
  AST_MV_MAP: assert property (o_target_mv == 16'h02A8 + 16'h000A * {9'h000, o_target_code})
    else $error("target millivolts do not follow the code");
  AST_MV_RANGE: assert property (o_target_mv >= 16'h02A8 && o_target_mv <= 16'h079E)
    else $error("target millivolts out of range");
  AST_BUSY: assert property (o_transition_busy == (o_vid_go && o_target_code != o_voltage_code))
    else $error("transition busy wrong");
  AST_NOGO_HOLD: assert property (!o_vid_go |=> $stable(o_target_code))
    else $error("target moved without go");
  AST_ONE_STEP: assert property ($changed(o_target_code) |->
    (o_target_code - $past(o_target_code) == 7'h01 || $past(o_target_code) - o_target_code == 7'h01))
    else $error("target jumped more than one step");
  AST_SDA_LOW: assert property (o_sda_oe |-> !o_sda_out)
    else $error("data line driven high");
  AST_SDA_STABLE: assert property (s_scl_high2 |-> $stable(o_sda_oe))
    else $error("acknowledge moved with bus clock high");
  AST_UPDATE_LOW: assert property ($changed({o_ch1_disable, o_ch2_disable, o_ch3_disable,
    o_ch1_light_load_sel, o_ch2_light_load_sel, o_ch3_light_load_sel, o_vid_go, o_voltage_code})
    |-> !i_scl) else $error("register changed with bus clock high");
  AST_RESET_ZERO: assert property ($fell(i_rst) |-> o_target_mv == 16'h02A8 &&
    {o_ch1_disable, o_ch2_disable, o_ch3_disable, o_ch1_light_load_sel, o_ch2_light_load_sel,
    o_ch3_light_load_sel, o_vid_go, o_voltage_code, o_target_code} == 21'h000000)
    else $error("fields not clear after reset");
endmodule
bind buck_regulator_control_regs buck_regs_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_scl(i_scl), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_ch1_disable(o_ch1_disable),
  .o_ch2_disable(o_ch2_disable), .o_ch3_disable(o_ch3_disable),
  .o_ch1_light_load_sel(o_ch1_light_load_sel), .o_ch2_light_load_sel(o_ch2_light_load_sel),
  .o_ch3_light_load_sel(o_ch3_light_load_sel), .o_vid_go(o_vid_go),
  .o_voltage_code(o_voltage_code), .o_target_code(o_target_code), .o_target_mv(o_target_mv),
  .o_transition_busy(o_transition_busy));

// file: tb/i2c_master_model.sv
// Two-wire bus master model that writes registers of the regulator bank.
module i2c_master_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: both lines released high.
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Each phase is four clocks, above the two-clock hold the sampler needs.
  task automatic w();
    repeat (4) @(posedge i_clk);
  endtask
  // One bit: data set while the clock is low, sampled while it is high.
  task automatic bt(input logic b, output logic s);
    o_sda <= b;
    w();
    o_scl <= 1'b1;
    w();
    s = i_sda;
    o_scl <= 1'b0;
    w();
  endtask
  // Eight bits most significant first, then the acknowledge slot with data released.
  task automatic bytew(input logic [7:0] v, inout logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bt(v[i], s);
    bt(1'b1, s);
    ack = ack & ~s;
  endtask
  // Start, address with write bit, register, data, stop.
  task automatic wr(input logic [6:0] a, input logic [7:0] r, d, output logic ack);
    ack = 1'b1;
    @(posedge i_clk) o_sda <= 1'b0;
    w();
    o_scl <= 1'b0;
    w();
    bytew({a, 1'b0}, ack);
    bytew(r, ack);
    bytew(d, ack);
    o_sda <= 1'b0;
    w();
    o_scl <= 1'b1;
    w();
    o_sda <= 1'b1;
    w();
  endtask
endmodule

// file: tb/buck_regulator_control_regs_tb.sv
// Testbench for the regulator control register bank.
module buck_regulator_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst = 1'b1, i_sw_tick = 1'b0, m_scl, m_sda, ack;
  logic o_sda_out, o_sda_oe, d1, d2, d3, l1, l2, l3, go, busy;
  logic [6:0] code, tgt;
  logic [15:0] mv;
  int err_total = 0, num_checks = 0;
  // Open-drain data line with pull-up.
  wire logic sda = m_sda & ~o_sda_oe;
  initial forever #2 i_clk = ~i_clk;
  buck_regulator_control_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_scl(m_scl), .i_sda(sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_sw_tick(i_sw_tick), .i_status(8'h5A),
    .o_ch1_disable(d1), .o_ch2_disable(d2), .o_ch3_disable(d3), .o_ch1_light_load_sel(l1),
    .o_ch2_light_load_sel(l2), .o_ch3_light_load_sel(l3), .o_vid_go(go), .o_voltage_code(code),
    .o_target_code(tgt), .o_target_mv(mv), .o_transition_busy(busy));
  i2c_master_model m (.i_clk(i_clk), .i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
  // Compare one result and count it.
  task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      $display("Error %s expected %0h seen %0h", n, e, s);
      err_total++;
    end
  endtask
  task automatic wreg(logic [6:0] a, logic [7:0] r, d);
    m.wr(a, r, d, ack);
    #1;
  endtask
  // Switching ticks are kept apart by a clock so each one is a single pulse.
  task automatic tk(int n);
    repeat (n) begin
      @(posedge i_clk) i_sw_tick <= 1'b1;
      @(posedge i_clk) i_sw_tick <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A hung run counts as a mismatch.
  initial begin
    #360000;
    err_total++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    cmp("reset fields", {d1, d2, d3, l1, l2, l3, go, code}, 16'h0000);
    cmp("reset mv", mv, 16'h02A8);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      for (int r = 3; r < 6; r++) wreg(7'h2A, 8'(r), 8'(i + 1));
      cmp("ack", ack, 1'b1);
      cmp("disables", {d1, d2, d3}, i == 0 ? 3'h7 : 3'h0);
      cmp("light load", {l1, l2, l3}, i == 0 ? 3'h0 : 3'h7);
    end
    wreg(7'h15, 8'h03, 8'h01);
    cmp("foreign ack", ack, 1'b0);
    cmp("foreign write", {d1, l1}, 2'h1);
    wreg(7'h2A, 8'h03, 8'hFC);
    cmp("spare bits", {d1, l1}, 2'h0);
    $display("test commands done");
    wreg(7'h2A, 8'h04, 8'h10);
    wreg(7'h2A, 8'h01, 8'h05);
    tk(4);
    cmp("no go target", {busy, tgt}, 8'h00);
    wreg(7'h2A, 8'h01, 8'h85);
    cmp("go and code", {go, code}, 8'h85);
    cmp("busy", busy, 1'b1);
    tk(4);
    cmp("half way", tgt, 7'h02);
    tk(6);
    cmp("target", {busy, tgt}, 8'h05);
    cmp("target mv", mv, 16'h02DA);
    wreg(7'h2A, 8'h04, 8'h00);
    wreg(7'h2A, 8'h01, 8'hFF);
    tk(122);
    cmp("top target", tgt, 7'h7F);
    cmp("top mv", mv, 16'h079E);
    wreg(7'h2A, 8'h04, 8'h70);
    wreg(7'h2A, 8'h01, 8'hFE);
    tk(127);
    cmp("slow hold", tgt, 7'h7F);
    tk(1);
    cmp("slow step", tgt, 7'h7E);
    $display("test slew done");
    end_of_test();
  end
endmodule
